// *** core/fspc_host.sv ***
// Host controller driving the protect, unprotect and verify pin sequences
// Notes on behaviour
// - Elevated reset pin temporarily unprotects sectors
// - Protect: elevated line nine, OE, write pulse
// - Verify: elevated line nine, bit one high
// - Identifier command then read gives protect bit
// - Reset command leaves identifier read mode
// - Unprotect: elevated OE, line nine, bit six
// - Protect all sectors before chip unprotect; OP_UNPROTECT does not do this, the caller protects each sector first
// - Write needs CE, WE low, OE high
`timescale 1ns/1ps
`default_nettype none
module fspc_host
  import fspc_pkg::*;
#(
  parameter int PROT_PULSE_CYC = WP_PROT_CYC,
  parameter int UNPROT_PULSE_CYC = WP_UNPROT_CYC,
  parameter int SETTLE_CYC = VLHT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire fspc_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] status_o,
  output fspc_pins_t pins_o,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic [7:0] dq_i
);
  // Counters are 16 bits wide, so longer counts cannot be served
  if (PROT_PULSE_CYC < 1 || PROT_PULSE_CYC > 65535) begin : g_bad_prot
    $error("fspc_host: protect pulse count out of range");
  end
  if (UNPROT_PULSE_CYC < 1 || UNPROT_PULSE_CYC > 65535) begin : g_bad_unprot
    $error("fspc_host: unprotect pulse count out of range");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("fspc_host: settle count out of range");
  end

  typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_READ, S_CAPT, S_WCMD, S_WGAP, S_DONE} fspc_state_t;
  fspc_state_t state_r, state_nxt;
  fspc_cmd_t cmd_r;
  fspc_pins_t pins_r, pins_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [1:0] wstep_r, wstep_nxt;
  logic [7:0] status_r, status_nxt, dq_r, dq_nxt;
  logic dq_oe_r, dq_oe_nxt, temp_r, temp_nxt;
  logic [7:0] dq_sync;

  // Data bus from the flash is asynchronous to mclk_i
  fspc_sync #(.W(8)) u_dq_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(dq_i),
    .q_o(dq_sync)
  );

  // Elevated addresses: bit one high for verify; bits zero and six forced low,
  // since bit six high under elevated levels would unprotect the whole chip
  wire logic [ADDR_W-1:0] hv_verify_addr = ADDR_W'(1 << BIT_ADDR1);
  wire logic [ADDR_W-1:0] low_clr_mask = ~(ADDR_W'(1 << BIT_ADDR0) | ADDR_W'(1 << BIT_ADDR6));
  wire logic [ADDR_W-1:0] sector_sel = cmd_i.sector_addr & low_clr_mask;
  wire logic [ADDR_W-1:0] id_verify_addr = cmd_r.sector_addr | ADDR_W'(1 << BIT_ADDR1);
  wire logic [ADDR_W-1:0] unprot_addr = ADDR_W'(1 << BIT_ADDR6);
  wire logic is_unprot = (cmd_r.op == OP_UNPROTECT);
  wire logic [15:0] pulse_len = is_unprot ? 16'(UNPROT_PULSE_CYC) : 16'(PROT_PULSE_CYC);
  // Write step picks the byte: first enter identifier mode, then leave it
  wire logic [7:0] wcmd_byte = (wstep_r == 2'h0) ? CMD_ID_READ : CMD_RESET;

  assign cmd_ready_o = (state_r == S_IDLE);
  assign done_o = (state_r == S_DONE);
  assign status_o = status_r;
  assign pins_o = pins_r;
  assign dq_o = dq_r;
  assign dq_oe_o = dq_oe_r;

  // Sequencer for every operation
  always_comb begin
    state_nxt = state_r;
    pins_nxt = pins_r;
    cnt_nxt = cnt_r;
    wstep_nxt = wstep_r;
    status_nxt = status_r;
    dq_nxt = dq_r;
    dq_oe_nxt = dq_oe_r;
    temp_nxt = temp_r;
    case (state_r)
      S_IDLE: begin
        // Idle pins: deselected, write inhibited
        pins_nxt.ce_n = 1'b1;
        pins_nxt.oe_n = 1'b1;
        pins_nxt.we_n = 1'b1;
        pins_nxt.addr9_hv = 1'b0;
        pins_nxt.oe_hv = 1'b0;
        pins_nxt.reset_hv = temp_r;
        dq_oe_nxt = 1'b0;
        cnt_nxt = 16'h0000;
        if (cmd_valid_i) begin
          case (cmd_i.op)
            OP_PROTECT: begin
              pins_nxt.addr = sector_sel;
              pins_nxt.ce_n = 1'b0;
              pins_nxt.addr9_hv = 1'b1;
              pins_nxt.oe_hv = 1'b1;
              state_nxt = S_SETUP;
            end
            OP_UNPROTECT: begin
              pins_nxt.addr = unprot_addr;
              pins_nxt.ce_n = 1'b0;
              pins_nxt.addr9_hv = 1'b1;
              pins_nxt.oe_hv = 1'b1;
              state_nxt = S_SETUP;
            end
            OP_VERIFY_HV: begin
              pins_nxt.addr = sector_sel | hv_verify_addr;
              pins_nxt.addr9_hv = 1'b1;
              state_nxt = S_SETUP;
            end
            OP_VERIFY_ID: begin
              wstep_nxt = 2'h0;
              state_nxt = S_WCMD;
            end
            OP_TEMP_ON: begin
              temp_nxt = 1'b1;
              pins_nxt.reset_hv = 1'b1;
              state_nxt = S_HOLD;
            end
            OP_TEMP_OFF: begin
              temp_nxt = 1'b0;
              pins_nxt.reset_hv = 1'b0;
              state_nxt = S_HOLD;
            end
            default: state_nxt = S_DONE;
          endcase
        end
      end
      // Let elevated levels settle before the pulse or read
      S_SETUP: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= 16'(SETTLE_CYC)) begin
          cnt_nxt = 16'h0000;
          if (cmd_r.op == OP_VERIFY_HV) begin
            pins_nxt.ce_n = 1'b0;
            pins_nxt.oe_n = 1'b0;
            state_nxt = S_READ;
          end else begin
            pins_nxt.we_n = 1'b0;
            state_nxt = S_PULSE;
          end
        end
      end
      // Hold write enable low for the protect or unprotect pulse
      S_PULSE: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= pulse_len) begin
          pins_nxt.we_n = 1'b1;
          cnt_nxt = 16'h0000;
          state_nxt = S_HOLD;
        end
      end
      // Release elevated line nine and OE (reset keeps its level) and wait for the levels to settle
      S_HOLD: begin
        pins_nxt.addr9_hv = 1'b0;
        pins_nxt.oe_hv = 1'b0;
        pins_nxt.ce_n = 1'b1;
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= 16'(SETTLE_CYC)) begin
          state_nxt = S_DONE;
        end
      end
      // Wait access time plus synchroniser delay, then capture
      S_READ: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= 16'(ACC_CYC + 2)) begin
          state_nxt = S_CAPT;
        end
      end
      S_CAPT: begin
        // Bit zero shows protection; an unprotected sector reads zero
        status_nxt = dq_sync;
        pins_nxt.oe_n = 1'b1;
        pins_nxt.ce_n = 1'b1;
        cnt_nxt = 16'h0000;
        if (cmd_r.op == OP_VERIFY_ID) begin
          wstep_nxt = 2'h1;
          state_nxt = S_WCMD;
        end else begin
          state_nxt = S_HOLD;
        end
      end
      // Write one command byte: CE and WE low with OE high
      S_WCMD: begin
        pins_nxt.addr = '0;
        pins_nxt.ce_n = 1'b0;
        pins_nxt.oe_n = 1'b1;
        pins_nxt.we_n = 1'b0;
        dq_nxt = wcmd_byte;
        dq_oe_nxt = 1'b1;
        state_nxt = S_WGAP;
      end
      S_WGAP: begin
        pins_nxt.we_n = 1'b1;
        pins_nxt.ce_n = 1'b1;
        dq_oe_nxt = 1'b0;
        if (wstep_r == 2'h0) begin
          // Identifier mode entered; read with address bit one high
          pins_nxt.addr = id_verify_addr;
          pins_nxt.ce_n = 1'b0;
          pins_nxt.oe_n = 1'b0;
          cnt_nxt = 16'h0000;
          state_nxt = S_READ;
        end else begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // State registers; pins start safe so the flash stays in array read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      pins_r <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr9_hv: 1'b0, oe_hv: 1'b0, reset_hv: 1'b0};
      cnt_r <= 16'h0000;
      wstep_r <= 2'h0;
      status_r <= STATUS_CLEAR;
      dq_r <= 8'h00;
      dq_oe_r <= 1'b0;
      temp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      wstep_r <= wstep_nxt;
      status_r <= status_nxt;
      dq_r <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      temp_r <= temp_nxt;
    end
  end

  // Command is latched when taken
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_r <= '0;
    end else if (cmd_valid_i && state_r == S_IDLE) begin
      cmd_r <= cmd_i;
    end
  end
endmodule
`default_nettype wire

// *** core/fspc_pkg.sv ***
// Package for the flash sector protection host controller
package fspc_pkg;
  // Pin timing figures in ns and their cycle counts at 100 ns per clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int WP_PROT_MIN_NS = 100;
  localparam int WP_PROT_CYC = (WP_PROT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_UNPROT_MIN_NS = 100;
  localparam int WP_UNPROT_CYC = (WP_UNPROT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VLHT_NS = 4000;
  localparam int VLHT_CYC = (VLHT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_NS = 90;
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_EXTRA_NS = 30;
  localparam int SLEEP_CYC = (ACC_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Address bit positions and command bytes
  localparam int ADDR_W = 20;
  localparam int BIT_ADDR0 = 0;
  localparam int BIT_ADDR1 = 1;
  localparam int BIT_ADDR6 = 6;
  localparam logic [7:0] CMD_ID_READ = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;
  localparam logic [2:0] OP_PROTECT = 3'h0;
  localparam logic [2:0] OP_UNPROTECT = 3'h1;
  localparam logic [2:0] OP_VERIFY_HV = 3'h2;
  localparam logic [2:0] OP_VERIFY_ID = 3'h3;
  localparam logic [2:0] OP_TEMP_ON = 3'h4;
  localparam logic [2:0] OP_TEMP_OFF = 3'h5;

  // Command from the user side
  typedef struct packed {
    logic [2:0] op;
    logic [ADDR_W-1:0] sector_addr;
  } fspc_cmd_t;

  // Pins toward the flash
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic addr9_hv;
    logic oe_hv;
    logic reset_hv;
  } fspc_pins_t;
endpackage

// *** core/fspc_sync.sv ***
// Two flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fspc_sync #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // A zero-width bus has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("fspc_sync: width must be at least one");
  end
  logic [W-1:0] meta_r;
  // First stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** verif/fspc_flash_model.sv ***
// Behavioural flash device answering the sector protection pin sequences
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model
  import fspc_pkg::*;
#(
  parameter int DLY_NS = 0,
  parameter logic [7:0] ID_CODE = 8'hA5 // Arbitrary value
) (
  input wire fspc_pins_t pins_i,
  input wire logic [7:0] host_dq_i,
  input wire logic host_oe_i,
  output logic [7:0] dq_o
);
  // Elevated reset only lifts write blocking, bits stay, so protection returns
  logic [15:0] prot_r = 16'h0000;
  logic id_r = 1'b0;
  logic [7:0] last_r = 8'h00;
  logic c_hv = 1'b0, c_wr = 1'b0, c_a6 = 1'b0;
  logic [3:0] c_sec = 4'h0;
  logic [7:0] c_d = 8'h00;
  wire [3:0] sec = pins_i.addr[19:16];
  wire hv = pins_i.addr9_hv && pins_i.oe_hv;
  wire rd_en = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n;
  // No program path, array never changes sleep is invisible
  wire [7:0] rd_nxt = !(pins_i.addr9_hv || id_r) ? 8'hFF :
    pins_i.addr[1] ? {7'h00, prot_r[sec]} : ID_CODE;
  // A released bus shows the inverse of the last value, never a stale copy
  always @* if (rd_en) last_r = rd_nxt;
  assign #(DLY_NS) dq_o = rd_en ? last_r : ~last_r;
  // Qualifiers sampled just after the pulse opens, clear of edge races
  always @(negedge pins_i.we_n) begin
    #1;
    c_hv = hv && !pins_i.ce_n;
    c_wr = !pins_i.ce_n && pins_i.oe_n && !hv && host_oe_i;
    c_a6 = pins_i.addr[6];
    c_sec = sec;
    c_d = host_dq_i;
  end
  // Changes land on the closing edge of the pulse
  always @(posedge pins_i.we_n) begin
    if (c_hv && c_a6) prot_r = 16'h0000;
    else if (c_hv) prot_r[c_sec] = 1'b1;
    else if (c_wr && c_d == CMD_ID_READ) id_r = 1'b1;
    else if (c_wr && c_d == CMD_RESET) id_r = 1'b0;
    c_hv = 1'b0;
    c_wr = 1'b0;
  end
endmodule
`default_nettype wire

// *** verif/fspc_host_chk.sv ***
// Concurrent checks on the host controller ports
`timescale 1ns/1ps
`default_nettype none
module fspc_host_chk
  import fspc_pkg::*;
#(
  parameter int PROT_PULSE_CYC = 1,
  parameter int UNPROT_PULSE_CYC = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire fspc_cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic [7:0] status_o,
  input wire fspc_pins_t pins_o,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic [7:0] dq_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] wl_r;
  // Length of the current write pulse
  always_ff @(posedge mclk_i) wl_r <= (rst_i || pins_o.we_n) ? 16'h0000 : wl_r + 16'h0001;
  sequence s_id_wr; $fell(pins_o.we_n) && dq_o == CMD_ID_READ; endsequence
  sequence s_rst_wr; $fell(pins_o.we_n) && dq_o == CMD_RESET; endsequence
  AST_WR_OE: assert property (!pins_o.we_n && !pins_o.ce_n |-> pins_o.oe_n || pins_o.oe_hv)
    else $error("write with output enable low");
  AST_HV_ENTRY: assert property ($fell(pins_o.we_n) && pins_o.addr9_hv |-> pins_o.oe_hv && !pins_o.ce_n)
    else $error("elevated pulse without elevated OE or CE");
  AST_PULSE: assert property ($rose(pins_o.we_n) && $past(pins_o.addr9_hv) |->
    wl_r == ($past(pins_o.addr[6]) ? UNPROT_PULSE_CYC : PROT_PULSE_CYC))
    else $error("elevated write pulse length wrong");
  AST_SETTLE: assert property ($rose(pins_o.addr9_hv) |-> pins_o.we_n [*2])
    else $error("pulse too soon after elevation");
  AST_HV_READ: assert property (!pins_o.oe_n && !pins_o.oe_hv && pins_o.addr9_hv |-> pins_o.addr[1]
    && !pins_o.addr[0] && !pins_o.addr[6] && pins_o.we_n && !pins_o.ce_n)
    else $error("elevated read with wrong pins");
  AST_CMD_WR: assert property ($fell(pins_o.we_n) && !pins_o.addr9_hv |-> dq_oe_o && pins_o.oe_n
    && (dq_o == CMD_ID_READ || dq_o == CMD_RESET))
    else $error("bad command write");
  AST_ID_EXIT: assert property (s_id_wr |-> ##[1:60] s_rst_wr)
    else $error("identifier mode not left");
  AST_TAKE: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
    else $error("request not taken");
  AST_IDLE_HV: assert property (cmd_ready_o |-> !pins_o.addr9_hv && !pins_o.oe_hv && pins_o.we_n)
    else $error("elevated level while idle");
endmodule
bind fspc_host fspc_host_chk #(.PROT_PULSE_CYC(PROT_PULSE_CYC), .UNPROT_PULSE_CYC(UNPROT_PULSE_CYC))
  fspc_host_chk_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .cmd_ready_o(cmd_ready_o), .done_o(done_o), .status_o(status_o), .pins_o(pins_o), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .dq_i(dq_i));
`default_nettype wire

// *** verif/fspc_host_tb.sv ***
// Self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module fspc_host_tb import fspc_pkg::*; ;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  fspc_cmd_t cmd_i = '0;
  logic cmd_ready_o, done_o, dq_oe_o;
  logic [7:0] status_o, dq_o, dq_i;
  fspc_pins_t pins_o;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  // Short settle keeps the run brief
  fspc_host #(.SETTLE_CYC(2)) fspc_host_inst (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .status_o(status_o), .pins_o(pins_o),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
  // Slow answer, well inside the capture wait
  fspc_flash_model #(.DLY_NS(30)) fspc_flash_model_inst (.pins_i(pins_o), .host_dq_i(dq_o),
    .host_oe_i(dq_oe_o), .dq_o(dq_i));
  // Clock
  initial forever #50 mclk_i = ~mclk_i;
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request, then a bounded wait for its one-cycle done
  task automatic run_op(input logic [2:0] op, input logic [3:0] sec);
    int i;
    @(posedge mclk_i);
    #1;
    cmd_i = '{op: op, sector_addr: {sec, 16'h0000}};
    cmd_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
    cmd_valid_i = 1'b0;
    i = 0;
    while (done_o !== 1'b1 && i < 300) begin
      @(posedge mclk_i);
      #1;
      i++;
    end
    chk8("done", 8'h01, {7'h00, done_o});
  endtask
  task automatic t_reset;
    chk8("ready", 8'h01, {7'h00, cmd_ready_o});
    chk8("status", STATUS_CLEAR, status_o);
    chk8("idle pins", 8'h07, {5'h00, pins_o.ce_n, pins_o.we_n, pins_o.oe_n});
    chk8("idle hv", 8'h00, {5'h00, pins_o.addr9_hv, pins_o.oe_hv, pins_o.reset_hv});
    chk8("id mode", 8'h00, {7'h00, fspc_flash_model_inst.id_r});
    $display("test reset done");
  endtask
  task automatic t_protect;
    run_op(OP_VERIFY_HV, 4'h3);
    chk8("status", 8'h00, status_o);
    run_op(OP_PROTECT, 4'h3);
    run_op(OP_VERIFY_HV, 4'h3);
    chk8("status", 8'h01, status_o);
    run_op(OP_VERIFY_HV, 4'h5);
    chk8("status", 8'h00, status_o);
    $display("test protect done");
  endtask
  task automatic t_id;
    run_op(OP_VERIFY_ID, 4'h3);
    chk8("status", 8'h01, status_o);
    chk8("id mode", 8'h00, {7'h00, fspc_flash_model_inst.id_r});
    $display("test id done");
  endtask
  task automatic t_unprotect;
    // Every sector is locked first, so the chip unprotect has work on all of them
    for (int s = 0; s < 16; s++) begin
      run_op(OP_PROTECT, 4'(s));
    end
    run_op(OP_VERIFY_HV, 4'hF);
    chk8("status", 8'h01, status_o);
    run_op(OP_UNPROTECT, 4'h0);
    run_op(OP_VERIFY_ID, 4'h3);
    chk8("status", 8'h00, status_o);
    run_op(OP_VERIFY_HV, 4'h5);
    chk8("status", 8'h00, status_o);
    run_op(OP_VERIFY_HV, 4'hF);
    chk8("status", 8'h00, status_o);
    $display("test unprotect done");
  endtask
  task automatic t_temp;
    run_op(OP_PROTECT, 4'h2);
    run_op(OP_TEMP_ON, 4'h0);
    chk8("elevated reset", 8'h01, {7'h00, pins_o.reset_hv});
    run_op(3'h7, 4'h0);
    chk8("elevated reset", 8'h01, {7'h00, pins_o.reset_hv});
    run_op(OP_TEMP_OFF, 4'h0);
    chk8("elevated reset", 8'h00, {7'h00, pins_o.reset_hv});
    run_op(OP_VERIFY_ID, 4'h2);
    chk8("status", 8'h01, status_o);
    $display("test temp done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_reset;
    t_protect;
    t_id;
    t_unprotect;
    t_temp;
    wrap_up;
  end
endmodule
`default_nettype wire
